// >>> src/frb_params.svh
// Constants for the field reversal braking sequencer
`ifndef FRB_PARAMS_SVH
`define FRB_PARAMS_SVH

// Clock and times
`define FRB_CLK_HZ 40000000
`define FRB_DEBOUNCE_MS 30
`define FRB_TICK_MS 100

// Register byte addresses
`define FRB_ADDR_CTRL 8'h00
`define FRB_ADDR_FMIN 8'h04
`define FRB_ADDR_FACTOR 8'h08
`define FRB_ADDR_SPDMIN 8'h0C
`define FRB_ADDR_DLY0 8'h10
`define FRB_ADDR_STATUS 8'h24

// Field values and reset values
`define FRB_DLY_NUM 5
`define FRB_DLY_MAX 7'h64
`define FRB_DLY0_RST 7'h1E
`define FRB_DLY1_RST 7'h02
`define FRB_DLY2_RST 7'h01
`define FRB_DLY3_RST 7'h1E
`define FRB_DLY4_RST 7'h1E
`define FRB_SRC_EMF 2'h3
`define FRB_SRC_RST 2'h0
`define FRB_FMIN_RST 16'h0100
`define FRB_FACTOR_RST 8'hE6
`define FRB_SPDMIN_RST 16'h0040
`define FRB_IDX_ARM_BRAKE 3'h3
`define FRB_IDX_ARM_RESTORE 3'h4

`endif

// >>> src/frb_pkg.sv
// Types of the field reversal braking sequencer
package frb_pkg;
	typedef enum logic [11:0] {
		ST_IDLE = 12'h001,
		ST_ARM_ZERO = 12'h002,
		ST_FLD_DECAY = 12'h004,
		ST_DLY_OPEN = 12'h008,
		ST_DLY_CLOSE = 12'h010,
		ST_DLY_FIRE = 12'h020,
		ST_FLD_BUILD = 12'h040,
		ST_DLY_ARM = 12'h080,
		ST_RAMP = 12'h100,
		ST_STOP_ZERO = 12'h200,
		ST_HOLD = 12'h400,
		ST_RESTART = 12'h800
	} state_t;
endpackage

// >>> src/delay_timer.sv
// Programmable delay counter in steps of one tick
`timescale 1ns/10ps
module delay_timer #(
	parameter int TICK_CYC = 4000000,
	parameter int DW = 7
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	input wire logic [DW-1:0] tenths,
	output logic done
);
	localparam int PW = $clog2(TICK_CYC + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);

	logic busy_q, busy_d, done_q, done_d;
	logic [DW-1:0] rem_q, rem_d;
	logic [PW-1:0] pre_q, pre_d;

	always_comb begin
		busy_d = busy_q;
		rem_d = rem_q;
		pre_d = pre_q;
		done_d = 1'b0;
		if (start) begin
			busy_d = 1'b1;
			rem_d = tenths;
			pre_d = '0;
		end else if (busy_q) begin
			if (rem_q == '0) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end else if (pre_q == PRE_LAST) begin
				pre_d = '0;
				rem_d = rem_q - DW'(1);
			end else begin
				pre_d = pre_q + PW'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			rem_q <= '0;
			pre_q <= '0;
			done_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
			rem_q <= rem_d;
			pre_q <= pre_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule

// >>> src/field_reversal_braking_sequencer.sv
// Braking by field reversal for a two-quadrant DC drive, APB slave
//
// Summary of operation
// R1 - Accept brake after 30 ms command, line closed
// R2 - Ignore brake request while sequence running
// R3 - Negative internal speed flags braking active
// R4 - Zero armature current, then inhibit armature pulses
// R5 - Block field pulses, wait field below minimum
// R6 - First delay, then open present contactor
// R7 - Second delay, then close opposite contactor
// R8 - Invert speed value unless EMF source
// R9 - Third delay, then enable field pulses
// R10 - Field above setpoint times factor, fourth delay
// R11 - Force zero speed setpoint until below minimum
// R12 - Zero current, inhibit armature, enter braked hold
// R13 - Hold braked state while command stays high
// R14 - Restore field only if direction differs
// R15 - Restore repeats steps, fifth delay, arm enable
// R16 - Restart needs external stop then switch-on
// R17 - Bit 0 positive contactor, bit 1 negative
// R18 - Select low means positive, high negative
// R19 - Delays timed in 0.1 s, range checked
`timescale 1ns/10ps
`include "frb_params.svh"
module field_reversal_braking_sequencer #(
	parameter int DEBOUNCE_CYC = `FRB_CLK_HZ / 1000 * `FRB_DEBOUNCE_MS,
	parameter int TICK_CYC = `FRB_CLK_HZ / 1000 * `FRB_TICK_MS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins from outside the clock domain
	input wire logic braking_command_input,
	input wire logic direction_reversal_select,
	input wire logic ext_stop_cmd,
	input wire logic switch_on_cmd,
	// Drive signals on the control clock
	input wire logic line_contactor_closed,
	input wire logic armature_current_zero,
	input wire logic [15:0] field_current_actual,
	input wire logic [15:0] field_current_setpoint,
	input wire logic [15:0] speed_actual_raw,
	// Drive outputs
	output logic field_contactor_pos_out,
	output logic field_contactor_neg_out,
	output logic armature_pulse_inhibit,
	output logic field_pulse_inhibit,
	output logic state_armature_inhibited,
	output logic state_braked_hold,
	output logic speed_setpoint_force_zero,
	output logic [15:0] speed_actual_internal,
	output logic braking_active
);
	localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
	localparam logic [DBW-1:0] DEB_FULL = DBW'(DEBOUNCE_CYC);
	localparam logic [6:0] DLY_RST [`FRB_DLY_NUM] = '{`FRB_DLY0_RST,
		`FRB_DLY1_RST, `FRB_DLY2_RST, `FRB_DLY3_RST, `FRB_DLY4_RST};

	// Pin synchronisers and command debounce
	logic [3:0] sync1_q, sync2_q;
	logic [DBW-1:0] deb_q, deb_d;
	logic cmd_s, dir_s, stop_s, son_s, cmd_ok;

	assign cmd_s = sync2_q[0];
	assign dir_s = sync2_q[1];
	assign stop_s = sync2_q[2];
	assign son_s = sync2_q[3];
	assign cmd_ok = cmd_s && (deb_q == DEB_FULL); // [R1]

	always_comb begin
		deb_d = '0;
		if (cmd_s) begin
			deb_d = (deb_q == DEB_FULL) ? deb_q : deb_q + DBW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			deb_q <= '0;
		end else begin
			sync1_q <= {switch_on_cmd, ext_stop_cmd,
				direction_reversal_select, braking_command_input};
			sync2_q <= sync1_q;
			deb_q <= deb_d;
		end
	end

	// Register file
	logic [1:0] src_q, src_d;
	logic [15:0] fmin_q, fmin_d, spdmin_q, spdmin_d;
	logic [7:0] factor_q, factor_d;
	logic [6:0] dly_q [`FRB_DLY_NUM];
	logic [6:0] dly_d [`FRB_DLY_NUM];
	logic pready_d, pslverr_d;
	logic [31:0] prdata_d, status_w;
	logic acc, wr_now;
	frb_pkg::state_t state_q, state_d;
	logic contact_on_q, contact_on_d, field_dir_q, field_dir_d;
	logic hold_q, hold_d, braking_q, braking_d, restore_q, restore_d;

	assign acc = psel && penable;
	assign wr_now = acc && pwrite && pready;
	assign status_w = {11'h000, restore_q, braking_q, hold_q, field_dir_q,
		contact_on_q, 4'h0, 12'(state_q)};

	// One wait state: pready rises the cycle after access is seen
	always_comb begin
		src_d = src_q;
		fmin_d = fmin_q;
		factor_d = factor_q;
		spdmin_d = spdmin_q;
		dly_d = dly_q;
		pready_d = acc && !pready;
		pslverr_d = 1'b0;
		prdata_d = '0;
		if (acc && !pready) begin
			unique case (paddr)
				`FRB_ADDR_CTRL: prdata_d = {30'h0, src_q};
				`FRB_ADDR_FMIN: prdata_d = {16'h0, fmin_q};
				`FRB_ADDR_FACTOR: prdata_d = {24'h0, factor_q};
				`FRB_ADDR_SPDMIN: prdata_d = {16'h0, spdmin_q};
				`FRB_ADDR_STATUS: prdata_d = status_w;
				default: pslverr_d = 1'b1;
			endcase
			for (int i = 0; i < `FRB_DLY_NUM; i++) begin
				if (paddr == `FRB_ADDR_DLY0 + 8'(4 * i)) begin
					pslverr_d = pwrite && (pwdata[31:0] > 32'(`FRB_DLY_MAX)); // [R19]
					prdata_d = {25'h0, dly_q[i]};
				end
			end
			if (pwrite) begin
				prdata_d = '0;
			end
		end
		if (wr_now) begin
			unique case (paddr)
				`FRB_ADDR_CTRL: src_d = pwdata[1:0];
				`FRB_ADDR_FMIN: fmin_d = pwdata[15:0];
				`FRB_ADDR_FACTOR: factor_d = pwdata[7:0];
				`FRB_ADDR_SPDMIN: spdmin_d = pwdata[15:0];
				default: ;
			endcase
			for (int i = 0; i < `FRB_DLY_NUM; i++) begin
				if (paddr == `FRB_ADDR_DLY0 + 8'(4 * i)) begin
					// Out of range values clamp to ten seconds
					dly_d[i] = (pwdata > 32'(`FRB_DLY_MAX)) ?
						`FRB_DLY_MAX : pwdata[6:0]; // [R19]
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= `FRB_SRC_RST;
			fmin_q <= `FRB_FMIN_RST;
			factor_q <= `FRB_FACTOR_RST;
			spdmin_q <= `FRB_SPDMIN_RST;
			dly_q <= DLY_RST;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			src_q <= src_d;
			fmin_q <= fmin_d;
			factor_q <= factor_d;
			spdmin_q <= spdmin_d;
			dly_q <= dly_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			prdata <= prdata_d;
		end
	end

	// Sequencer
	logic arm_inh_q, arm_inh_d, fld_blk_q, fld_blk_d, zero_set_q, zero_set_d;
	logic stop_seen_q, stop_seen_d, tmr_start_q, tmr_start_d, tmr_done;
	logic [2:0] tmr_idx_q, tmr_idx_d;
	logic [15:0] spd_d;
	logic [16:0] spd_mag;
	logic [23:0] fld_target;
	logic fld_ok, fld_low, spd_low;

	assign fld_target = field_current_setpoint * factor_q;
	assign fld_ok = {field_current_actual, 8'h00} > fld_target; // [R10]
	assign fld_low = field_current_actual < fmin_q; // [R5]
	assign spd_mag = speed_actual_internal[15] ?
		17'h00000 - {1'b1, speed_actual_internal} :
		{1'b0, speed_actual_internal};
	assign spd_low = spd_mag < {1'b0, spdmin_q}; // [R11]

	delay_timer #(
		.TICK_CYC(TICK_CYC),
		.DW(7)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(tmr_start_q),
		.tenths(dly_q[tmr_idx_q]), // [R19]
		.done(tmr_done)
	);

	always_comb begin
		state_d = state_q;
		contact_on_d = contact_on_q;
		field_dir_d = field_dir_q;
		hold_d = hold_q;
		braking_d = braking_q;
		restore_d = restore_q;
		arm_inh_d = arm_inh_q;
		fld_blk_d = fld_blk_q;
		zero_set_d = zero_set_q;
		stop_seen_d = stop_seen_q;
		tmr_start_d = 1'b0;
		tmr_idx_d = tmr_idx_q;
		unique case (state_q)
			frb_pkg::ST_IDLE: begin
				// Requests count only from idle
				if (cmd_ok && line_contactor_closed) begin // [R1] [R2]
					state_d = frb_pkg::ST_ARM_ZERO;
					braking_d = 1'b1;
					restore_d = 1'b0;
				end
			end
			frb_pkg::ST_ARM_ZERO: begin
				if (armature_current_zero) begin
					arm_inh_d = 1'b1; // [R4]
					state_d = frb_pkg::ST_FLD_DECAY;
				end
			end
			frb_pkg::ST_FLD_DECAY: begin
				fld_blk_d = 1'b1; // [R5]
				if (fld_low && fld_blk_q) begin
					state_d = frb_pkg::ST_DLY_OPEN;
					tmr_start_d = 1'b1;
					tmr_idx_d = 3'h0;
				end
			end
			frb_pkg::ST_DLY_OPEN: begin
				if (tmr_done) begin
					contact_on_d = 1'b0; // [R6]
					state_d = frb_pkg::ST_DLY_CLOSE;
					tmr_start_d = 1'b1;
					tmr_idx_d = 3'h1;
				end
			end
			frb_pkg::ST_DLY_CLOSE: begin
				if (tmr_done) begin
					contact_on_d = 1'b1; // [R7]
					field_dir_d = !field_dir_q;
					state_d = frb_pkg::ST_DLY_FIRE;
					tmr_start_d = 1'b1;
					tmr_idx_d = 3'h2;
				end
			end
			frb_pkg::ST_DLY_FIRE: begin
				if (tmr_done) begin
					fld_blk_d = 1'b0; // [R9]
					state_d = frb_pkg::ST_FLD_BUILD;
				end
			end
			frb_pkg::ST_FLD_BUILD: begin
				if (fld_ok) begin // [R10]
					state_d = frb_pkg::ST_DLY_ARM;
					tmr_start_d = 1'b1;
					tmr_idx_d = restore_q ? `FRB_IDX_ARM_RESTORE :
						`FRB_IDX_ARM_BRAKE; // [R15]
				end
			end
			frb_pkg::ST_DLY_ARM: begin
				if (tmr_done) begin
					arm_inh_d = 1'b0; // [R10] [R15]
					state_d = restore_q ? frb_pkg::ST_RESTART :
						frb_pkg::ST_RAMP;
				end
			end
			frb_pkg::ST_RAMP: begin
				zero_set_d = 1'b1; // [R11]
				if (spd_low) begin
					state_d = frb_pkg::ST_STOP_ZERO;
				end
			end
			frb_pkg::ST_STOP_ZERO: begin
				if (armature_current_zero) begin
					arm_inh_d = 1'b1; // [R12]
					hold_d = 1'b1;
					state_d = frb_pkg::ST_HOLD;
				end
			end
			frb_pkg::ST_HOLD: begin
				if (!cmd_s) begin // [R13]
					// Back to the direction the select pin asks for
					if (field_dir_q != dir_s) begin // [R14] [R18]
						restore_d = 1'b1;
						state_d = frb_pkg::ST_ARM_ZERO;
					end else begin
						arm_inh_d = 1'b0;
						state_d = frb_pkg::ST_RESTART;
					end
				end
			end
			frb_pkg::ST_RESTART: begin
				zero_set_d = 1'b0;
				if (stop_s) begin
					stop_seen_d = 1'b1;
				end
				if (stop_seen_q && son_s && !stop_s) begin // [R16]
					stop_seen_d = 1'b0;
					hold_d = 1'b0;
					braking_d = 1'b0;
					restore_d = 1'b0;
					state_d = frb_pkg::ST_IDLE;
				end
			end
		endcase
		// Internal speed follows the field unless it is the EMF
		spd_d = speed_actual_raw;
		if (field_dir_d && src_q != `FRB_SRC_EMF) begin // [R3] [R8]
			spd_d = 16'h0000 - speed_actual_raw;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= frb_pkg::ST_IDLE;
			contact_on_q <= 1'b1;
			field_dir_q <= 1'b0;
			hold_q <= 1'b0;
			braking_q <= 1'b0;
			restore_q <= 1'b0;
			arm_inh_q <= 1'b0;
			fld_blk_q <= 1'b0;
			zero_set_q <= 1'b0;
			stop_seen_q <= 1'b0;
			tmr_start_q <= 1'b0;
			tmr_idx_q <= 3'h0;
			field_contactor_pos_out <= 1'b1;
			field_contactor_neg_out <= 1'b0;
			armature_pulse_inhibit <= 1'b0;
			field_pulse_inhibit <= 1'b0;
			state_armature_inhibited <= 1'b0;
			state_braked_hold <= 1'b0;
			speed_setpoint_force_zero <= 1'b0;
			speed_actual_internal <= 16'h0000;
			braking_active <= 1'b0;
		end else begin
			state_q <= state_d;
			contact_on_q <= contact_on_d;
			field_dir_q <= field_dir_d;
			hold_q <= hold_d;
			braking_q <= braking_d;
			restore_q <= restore_d;
			arm_inh_q <= arm_inh_d;
			fld_blk_q <= fld_blk_d;
			zero_set_q <= zero_set_d;
			stop_seen_q <= stop_seen_d;
			tmr_start_q <= tmr_start_d;
			tmr_idx_q <= tmr_idx_d;
			field_contactor_pos_out <= contact_on_d && !field_dir_d; // [R17]
			field_contactor_neg_out <= contact_on_d && field_dir_d; // [R17]
			armature_pulse_inhibit <= arm_inh_d;
			field_pulse_inhibit <= fld_blk_d ||
				(field_current_setpoint == 16'h0000); // [R5]
			state_armature_inhibited <= arm_inh_d && !hold_d; // [R4]
			state_braked_hold <= hold_d; // [R13]
			speed_setpoint_force_zero <= zero_set_d; // [R11]
			speed_actual_internal <= spd_d;
			braking_active <= braking_d && spd_d[15]; // [R3]
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_ACCEPT_COND: assert property ($rose(braking_q) |-> // [R1]
		$past(cmd_ok) && $past(line_contactor_closed))
		else $error("brake accepted without debounced command");
	AST_NO_NEW_BRAKE: assert property (braking_q && // [R2]
		!$past(braking_q) |-> $past(state_q) == frb_pkg::ST_IDLE)
		else $error("brake started outside idle");
	AST_ACTIVE_NEG: assert property (braking_active |-> // [R3]
		speed_actual_internal[15] && braking_q)
		else $error("braking active without negative speed");
	AST_ARM_INH_ZERO: assert property ($rose(armature_pulse_inhibit) |-> // [R4]
		$past(armature_current_zero))
		else $error("armature inhibited with current flowing");
	AST_FLD_ZERO_SET: assert property ( // [R5]
		field_current_setpoint == 16'h0000 |=> field_pulse_inhibit)
		else $error("field pulses free with zero setpoint");
	AST_OPEN_AFTER_DLY: assert property ($fell(contact_on_q) |-> // [R6]
		$past(state_q) == frb_pkg::ST_DLY_OPEN && $past(tmr_done))
		else $error("contactor opened outside first delay");
	AST_MAKE_AFTER_DLY: assert property ($rose(contact_on_q) |-> // [R7]
		$past(state_q) == frb_pkg::ST_DLY_CLOSE && field_dir_q != $past(field_dir_q))
		else $error("new contactor closed without reversal");
	AST_INVERT: assert property (field_dir_q && // [R8]
		$past(src_q) != `FRB_SRC_EMF |-> speed_actual_internal ==
		16'h0000 - $past(speed_actual_raw))
		else $error("speed not inverted in negative field");
	AST_ZERO_SET: assert property (state_q == frb_pkg::ST_RAMP |=> // [R11]
		speed_setpoint_force_zero)
		else $error("zero setpoint not forced while braking");
	AST_HOLD: assert property (state_q == frb_pkg::ST_HOLD && cmd_s |=> // [R13]
		state_q == frb_pkg::ST_HOLD ##0 state_braked_hold)
		else $error("braked hold left while command high");
	AST_RESTART_ACK: assert property ($fell(hold_q) |-> // [R16]
		$past(stop_seen_q) && $past(son_s))
		else $error("restart without stop and switch-on");
	AST_ONE_CONTACTOR: assert property (!(field_contactor_pos_out && // [R17]
		field_contactor_neg_out))
		else $error("both field contactors closed");
	AST_DLY_RANGE: assert property (tmr_start_q |-> // [R19]
		dly_q[tmr_idx_q] <= `FRB_DLY_MAX)
		else $error("delay out of range");
	AST_APB_WAIT: assert property (acc && !pready |=> pready ##1 !pready)
		else $error("APB answer not one wait state");

	COV_HOLD: cover property (state_q == frb_pkg::ST_HOLD);
	COV_RESTORE: cover property (restore_q && state_q == frb_pkg::ST_DLY_ARM);
	COV_RESTART: cover property ($fell(braking_q));
	COV_SLVERR: cover property (pready && pslverr);
endmodule

// >>> bench/drive_model.sv
// Behavioural field stage and armature current of the drive
`timescale 1ns/10ps
module drive_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// From the sequencer
	input wire logic field_contactor_pos_out,
	input wire logic field_contactor_neg_out,
	input wire logic field_pulse_inhibit,
	input wire logic armature_pulse_inhibit,
	// From the bench
	input wire logic ia_zero_req,
	// To the sequencer
	output logic [15:0] field_current_actual,
	output logic armature_current_zero
);
	logic [15:0] fld_q;
	logic [1:0] ia_q;
	logic on;
	// Current flows only through a closed contactor
	assign on = field_contactor_pos_out || field_contactor_neg_out;
	assign field_current_actual = fld_q;
	// Slow answer: armature current needs three cycles to die away
	assign armature_current_zero = (ia_q == 2'h3);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fld_q <= 16'h0000;
			ia_q <= 2'h0;
		end else begin
			if (on && !field_pulse_inhibit) begin
				fld_q <= (fld_q < 16'h1000) ? fld_q + 16'h0040 : fld_q;
			end else begin
				fld_q <= (fld_q > 16'h0040) ? fld_q - 16'h0040 : 16'h0000;
			end
			if (ia_zero_req || armature_pulse_inhibit) begin
				ia_q <= (ia_q == 2'h3) ? ia_q : ia_q + 2'h1;
			end else begin
				ia_q <= 2'h0;
			end
		end
	end
endmodule

// >>> bench/field_reversal_braking_sequencer_tb.sv
// Self-checking bench of the braking sequencer
`timescale 1ns/10ps
module field_reversal_braking_sequencer_tb;
	localparam int TK = 4;
	localparam logic [6:0] DRST [5] = '{7'h1E, 7'h02, 7'h01, 7'h1E, 7'h1E};
	localparam logic [6:0] DSET [5] = '{7'h01, 7'h02, 7'h01, 7'h02, 7'h01};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cmd, sel, stop, son, line, ia_req, aiz;
	logic pos, neg, ainh, finh, sainh, hold, fz, bact;
	logic [15:0] fact, fset, spd, sint;
	int miscompares, total_checks, n;

	field_reversal_braking_sequencer #(.DEBOUNCE_CYC(8), .TICK_CYC(TK)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .braking_command_input(cmd),
		.direction_reversal_select(sel), .ext_stop_cmd(stop),
		.switch_on_cmd(son), .line_contactor_closed(line),
		.armature_current_zero(aiz), .field_current_actual(fact),
		.field_current_setpoint(fset), .speed_actual_raw(spd),
		.field_contactor_pos_out(pos), .field_contactor_neg_out(neg),
		.armature_pulse_inhibit(ainh), .field_pulse_inhibit(finh),
		.state_armature_inhibited(sainh), .state_braked_hold(hold),
		.speed_setpoint_force_zero(fz), .speed_actual_internal(sint),
		.braking_active(bact));
	drive_model far_side (.pclk(pclk), .presetn(presetn),
		.field_contactor_pos_out(pos), .field_contactor_neg_out(neg),
		.field_pulse_inhibit(finh), .armature_pulse_inhibit(ainh),
		.ia_zero_req(ia_req), .field_current_actual(fact),
		.armature_current_zero(aiz));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Waits for a level on one output, n counts the edges
	task automatic wt(input int s, input logic v, input int lim);
		logic x;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			case (s)
				0: x = ainh;
				1: x = pos;
				2: x = neg;
				3: x = hold;
				default: x = finh;
			endcase
		end while (x !== v && n < lim);
		chk({31'h0, x}, {31'h0, v});
	endtask
	task automatic status_is(input logic [11:0] st);
		apb(1'b0, 8'h24, 32'h0);
		chk({20'h0, rd[11:0]}, {20'h0, st});
	endtask
	task automatic ack;
		stop <= 1'b1;
		cyc(5);
		stop <= 1'b0;
		cyc(5);
		son <= 1'b1;
		cyc(10);
		son <= 1'b0;
		cyc(3);
	endtask

	task automatic test_regs;
		chk({30'h0, pos, neg}, 32'h2);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h100);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'hE6);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h40);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
			chk(rd, {25'h0, DRST[i]});
		end
		status_is(12'h001);
		apb(1'b0, 8'h28, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 8'h10, 32'h65);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h64);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 8'h10 + 8'(4 * i), {25'h0, DSET[i]});
			chk({31'h0, er}, 32'h0);
		end
		fset <= 16'h0000;
		cyc(4);
		chk({31'h0, finh}, 32'h1);
		fset <= 16'h0800;
		cyc(80);
		$display("test_regs done");
	endtask
	task automatic test_debounce;
		cmd <= 1'b1;
		cyc(4);
		cmd <= 1'b0;
		cyc(20);
		status_is(12'h001);
		line <= 1'b0;
		cmd <= 1'b1;
		cyc(30);
		status_is(12'h001);
		// Line closes only once the synced command has gone low
		cmd <= 1'b0;
		cyc(4);
		line <= 1'b1;
		cyc(10);
		status_is(12'h001);
		$display("test_debounce done");
	endtask
	task automatic test_brake_restore;
		spd <= 16'h0200;
		ia_req <= 1'b0;
		cmd <= 1'b1;
		cyc(40);
		chk({31'h0, ainh}, 32'h0);
		chk({15'h0, bact, sint}, 32'h0200);
		ia_req <= 1'b1;
		wt(0, 1'b1, 20);
		cyc(1);
		chk({30'h0, sainh, finh}, 32'h3);
		wt(1, 1'b0, 2000);
		chk({31'h0, n >= DSET[0] * TK}, 32'h1);
		wt(2, 1'b1, 2000);
		chk({31'h0, n >= DSET[1] * TK && n <= DSET[1] * TK + 6}, 32'h1);
		cyc(2);
		chk({16'h0, sint}, 32'hFE00);
		chk({30'h0, bact, pos}, 32'h2);
		wt(4, 1'b0, 2000);
		chk({31'h0, n >= DSET[2] * TK && n <= DSET[2] * TK + 6}, 32'h1);
		wt(0, 1'b0, 4000);
		chk({31'h0, n >= DSET[3] * TK}, 32'h1);
		ia_req <= 1'b0;
		cyc(2);
		chk({31'h0, fz}, 32'h1);
		spd <= 16'h0010;
		cyc(30);
		chk({31'h0, hold}, 32'h0);
		ia_req <= 1'b1;
		wt(3, 1'b1, 40);
		chk({31'h0, ainh}, 32'h1);
		cyc(50);
		status_is(12'h400);
		// Releasing the key starts the field restore; the hold output stays set
		cmd <= 1'b0;
		wt(1, 1'b1, 4000);
		chk({31'h0, neg}, 32'h0);
		wt(0, 1'b0, 4000);
		cyc(2);
		chk({16'h0, sint}, 32'h0010);
		son <= 1'b1;
		cyc(10);
		son <= 1'b0;
		cyc(5);
		chk({31'h0, hold}, 32'h1);
		ack;
		chk({31'h0, hold}, 32'h0);
		status_is(12'h001);
		$display("test_brake_restore done");
	endtask
	task automatic test_brake_emf;
		apb(1'b1, 8'h00, 32'h3);
		sel <= 1'b1;
		spd <= 16'h0200;
		cmd <= 1'b1;
		wt(2, 1'b1, 4000);
		cyc(2);
		chk({15'h0, pos, sint}, 32'h0200);
		spd <= 16'h0010;
		wt(3, 1'b1, 8000);
		cmd <= 1'b0;
		cyc(300);
		chk({30'h0, pos, neg}, 32'h1);
		ack;
		status_is(12'h001);
		$display("test_brake_emf done");
	endtask

	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		miscompares = 0;
		total_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{cmd, sel, stop, son} = 4'h0;
		line = 1'b1;
		ia_req = 1'b1;
		fset = 16'h0800;
		spd = 16'h0200;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		test_regs;
		test_debounce;
		test_brake_restore;
		test_brake_emf;
		give_verdict;
	end
	// Whole run needs well under 20000 cycles
	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		give_verdict;
	end
endmodule
